//--- hdl/smsp_map.svh
// Constants for the serial master/slave port: field positions, resets, bit count, FIFO depth, divider width
`ifndef SMSP_MAP_SVH
`define SMSP_MAP_SVH
`define SMSP_CTRL_RESET      8'h00
`define SMSP_CTL_IRQ_EN      7
`define SMSP_CTL_PORT_EN     6
`define SMSP_CTL_ORDER       5
`define SMSP_CTL_MASTER      4
`define SMSP_CTL_CPOL        3
`define SMSP_CTL_CPHA        2
`define SMSP_CTL_RATE_HI     1
`define SMSP_CTL_RATE_LO     0
`define SMSP_STAT_DONE       7
`define SMSP_STAT_WRITE_COLLISION_FLAG       6
`define SMSP_STAT_DOUBLE     0
`define SMSP_BITS            4'h8
`define SMSP_FIFO_DEPTH      8
`define SMSP_DIV_BITS        7
`endif

//--- hdl/smsp_pkg.sv
// Types shared by the serial master/slave port
package smsp_pkg;
   typedef enum logic [1:0] {
      SMSP_IDLE,
      SMSP_SHIFT,
      SMSP_DONE
   } smsp_state_type;
endpackage

//--- hdl/smsp_fifo.sv
// Flip-flop FIFO with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
module smsp_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output var  logic             in_ready,
   output var  logic [WIDTH-1:0] out_data,
   output var  logic             out_valid,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0]    wp_r;
   logic [AW-1:0]    rp_r;
   logic [AW:0]      cnt_r;
   wire              push = in_valid && in_ready;
   wire              pop  = out_valid && out_ready;

   assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
   assign out_valid = (cnt_r != '0);
   assign out_data  = mem_r[rp_r];

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wp_r  <= '0;
         rp_r  <= '0;
         cnt_r <= '0;
      end else begin
         if (push) begin
            mem_r[wp_r] <= in_data;
            wp_r        <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + AW'(1);
         end
         if (pop)
            rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + AW'(1);
         if (push && !pop)
            cnt_r <= cnt_r + (AW+1)'(1);
         else if (pop && !push)
            cnt_r <= cnt_r - (AW+1)'(1);
      end
   end
endmodule // smsp_fifo
`default_nettype wire

//--- hdl/smsp_port.sv
// Serial master/slave byte port with control, status and data ports
`timescale 1ns/100ps
`default_nettype none
`include "smsp_map.svh"
module smsp_port (
   input  wire logic       CLK,
   input  wire logic       RST_N,
   input  wire logic [7:0] CTRL_WDATA,
   input  wire logic       CTRL_WE,
   input  wire logic       DOUBLE_WDATA,
   input  wire logic       DOUBLE_WE,
   input  wire logic       STATUS_RD,
   input  wire logic [7:0] DATA_WDATA,
   input  wire logic       DATA_WE,
   input  wire logic       DATA_RD,
   input  wire logic       IRQ_ACK,
   input  wire logic       SS_IS_INPUT,
   output logic      [7:0] CTRL_Q,
   output logic      [7:0] STATUS_Q,
   output logic      [7:0] RX_DATA,
   output logic            IRQ,
   input  wire logic       SCK_I,
   output logic            SCK_O,
   output logic            SCK_OE,
   input  wire logic       MOSI_I,
   output logic            MOSI_O,
   output logic            MOSI_OE,
   input  wire logic       MISO_I,
   output logic            MISO_O,
   output logic            MISO_OE,
   input  wire logic       SS_N_I,
   input  wire logic       MOSI_DIR_OUT,
   input  wire logic       SCK_DIR_OUT,
   input  wire logic       MISO_DIR_OUT,
   output logic      [7:0] RX_STREAM,
   output logic            RX_VALID,
   input  wire logic       RX_READY
);
   // -----------------------------------------------------------------
   // Control and status
   // -----------------------------------------------------------------
   smsp_pkg::smsp_state_type state_r;
   logic [7:0] ctrl_r;
   logic       double_r;
   logic       done_r;
   logic       write_collision_flag_r;
   logic       armed_r;
   logic [7:0] shreg_r;
   logic [3:0] bitcnt_r;
   logic [6:0] div_r;
   logic       half_r;
   logic       sck_r;
   logic       sck_prev_r;
   logic       ss_prev_r;
   logic       mosi_o_r;
   logic       miso_o_r;

   wire en       = ctrl_r[`SMSP_CTL_PORT_EN];
   wire master   = ctrl_r[`SMSP_CTL_MASTER];
   wire cpol     = ctrl_r[`SMSP_CTL_CPOL];
   wire cpha     = ctrl_r[`SMSP_CTL_CPHA];
   wire lsb      = ctrl_r[`SMSP_CTL_ORDER];
   wire busy     = (state_r == smsp_pkg::SMSP_SHIFT);
   wire selected = en && !master && !SS_N_I;
   // Mode fault: another master selected us
   wire mode_flt = en && master && SS_IS_INPUT && !SS_N_I;

   // Half-period in CLK cycles minus one: divisor / 2 - 1
   logic [6:0] half_div;
   always_comb begin
      case ({ctrl_r[`SMSP_CTL_RATE_HI], ctrl_r[`SMSP_CTL_RATE_LO]})
         2'b00:   half_div = double_r ? 7'h00 : 7'h01;
         2'b01:   half_div = double_r ? 7'h03 : 7'h07;
         2'b10:   half_div = double_r ? 7'h0f : 7'h1f;
         default: half_div = double_r ? 7'h1f : 7'h3f;
      endcase
   end

   // -----------------------------------------------------------------
   // Edge classification
   // -----------------------------------------------------------------
   wire tick      = busy && master && (div_r == half_div);
   // Master: leading edge when half_r is 0
   wire m_lead    = tick && !half_r;
   wire m_trail   = tick && half_r;
   // Slave edges from the sampled external clock; needs SCK <= CLK/4
   wire s_rise    = selected && SCK_I && !sck_prev_r;
   wire s_fall    = selected && !SCK_I && sck_prev_r;
   wire s_lead    = cpol ? s_fall : s_rise;
   wire s_trail   = cpol ? s_rise : s_fall;
   wire lead      = master ? m_lead : s_lead;
   wire trail     = master ? m_trail : s_trail;
   wire sample_e  = cpha ? trail : lead;
   wire setup_e   = cpha ? lead : trail;
   wire in_bit    = master ? MISO_I : MOSI_I;
   wire out_bit   = lsb ? shreg_r[0] : shreg_r[7];
   wire last_bit  = sample_e && (bitcnt_r == `SMSP_BITS - 4'h1);
   wire [7:0] shifted = lsb ? {in_bit, shreg_r[7:1]} : {shreg_r[6:0], in_bit};
   // Byte handed over: the last bit may arrive in the finishing cycle itself
   wire [7:0] rx_byte = sample_e ? shifted : shreg_r;
   // Completion: master after final trailing edge, slave on last sample
   // Phase 1 samples its eighth bit on that same trailing edge
   wire [3:0] m_last  = cpha ? `SMSP_BITS - 4'h1 : `SMSP_BITS;
   wire m_finish  = master && busy && m_trail && (bitcnt_r == m_last);
   wire s_finish  = !master && last_bit;
   wire finish    = m_finish || s_finish;
   wire start_m   = en && master && DATA_WE && !busy && !mode_flt;
   wire data_acc  = DATA_WE || DATA_RD;
   wire clr_flags = armed_r && data_acc;

   // -----------------------------------------------------------------
   // Sequencer
   // -----------------------------------------------------------------
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         state_r    <= smsp_pkg::SMSP_IDLE;
         ctrl_r     <= `SMSP_CTRL_RESET;
         double_r   <= 1'b0;
         shreg_r    <= 8'h00;
         bitcnt_r   <= 4'h0;
         div_r      <= 7'h00;
         half_r     <= 1'b0;
         sck_r      <= 1'b0;
         sck_prev_r <= 1'b0;
         ss_prev_r  <= 1'b1;
      end else begin
         sck_prev_r <= SCK_I;
         ss_prev_r  <= SS_N_I;
         if (DOUBLE_WE)
            double_r <= DOUBLE_WDATA;
         if (CTRL_WE)
            ctrl_r <= CTRL_WDATA;
         else if (mode_flt)
            ctrl_r[`SMSP_CTL_MASTER] <= 1'b0;
         // Idle level follows polarity, also right after a byte
         if (!busy && sck_r != cpol)
            sck_r <= cpol;
         case (state_r)
            // Done lasts one cycle and may already take the next write
            smsp_pkg::SMSP_IDLE, smsp_pkg::SMSP_DONE: begin
               // Slave preload: held until selected and clocked
               if (DATA_WE)
                  shreg_r <= DATA_WDATA;
               bitcnt_r <= 4'h0;
               if (start_m) begin
                  state_r <= smsp_pkg::SMSP_SHIFT;
                  div_r   <= 7'h00;
                  half_r  <= 1'b0;
               end else if (selected && ss_prev_r) begin
                  state_r <= smsp_pkg::SMSP_SHIFT;
               end else begin
                  state_r <= smsp_pkg::SMSP_IDLE;
               end
            end
            smsp_pkg::SMSP_SHIFT: begin
               if (master) begin
                  div_r <= tick ? 7'h00 : div_r + 7'h01;
                  if (tick) begin
                     half_r <= !half_r;
                     sck_r  <= !sck_r;
                  end
               end
               if (sample_e) begin
                  shreg_r  <= shifted;
                  bitcnt_r <= bitcnt_r + 4'h1;
               end
               // Deselect drops partial byte, mode fault aborts master
               if ((!master && (SS_N_I || !en)) || (master && (mode_flt || !en)))
                  state_r <= smsp_pkg::SMSP_IDLE;
               else if (finish)
                  state_r <= smsp_pkg::SMSP_DONE;
            end
            default: state_r <= smsp_pkg::SMSP_IDLE;
         endcase
      end
   end

   // -----------------------------------------------------------------
   // Data lines
   // -----------------------------------------------------------------
   // Phase 0 needs the first bit out before the leading edge,
   // so an idle port shows the byte being written this very cycle
   wire [7:0] load_src  = (DATA_WE && !busy) ? DATA_WDATA : shreg_r;
   wire       first_bit = lsb ? load_src[0] : load_src[7];
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         mosi_o_r <= 1'b0;
         miso_o_r <= 1'b0;
      end else if (!busy) begin
         mosi_o_r <= first_bit;
         miso_o_r <= first_bit;
      end else if (setup_e) begin
         mosi_o_r <= out_bit;
         miso_o_r <= out_bit;
      end
   end

   // -----------------------------------------------------------------
   // Flags, receive buffer and pin directions
   // -----------------------------------------------------------------
   logic [7:0] rxbuf_r;
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         done_r  <= 1'b0;
         write_collision_flag_r  <= 1'b0;
         armed_r <= 1'b0;
         rxbuf_r <= 8'h00;
      end else begin
         if (STATUS_RD)
            armed_r <= done_r || write_collision_flag_r;
         else if (data_acc)
            armed_r <= 1'b0;
         // Set wins over the clear in the same cycle
         if (finish || mode_flt)
            done_r <= 1'b1;
         else if (clr_flags || IRQ_ACK)
            done_r <= 1'b0;
         if (DATA_WE && busy)
            write_collision_flag_r <= 1'b1;
         else if (clr_flags)
            write_collision_flag_r <= 1'b0;
         // Older unread byte is overwritten here
         if (finish)
            rxbuf_r <= rx_byte;
      end
   end

   logic irq_r;
   logic sck_oe_r;
   logic mosi_oe_r;
   logic miso_oe_r;
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         irq_r     <= 1'b0;
         sck_oe_r  <= 1'b0;
         mosi_oe_r <= 1'b0;
         miso_oe_r <= 1'b0;
      end else begin
         irq_r     <= done_r && ctrl_r[`SMSP_CTL_IRQ_EN];
         sck_oe_r  <= en && master && SCK_DIR_OUT;
         mosi_oe_r <= en && master && MOSI_DIR_OUT;
         miso_oe_r <= selected && MISO_DIR_OUT;
      end
   end

   // Received bytes also stream out through a small FIFO
   logic [7:0] fifo_q;
   logic       fifo_v;
   smsp_fifo #(.WIDTH(8), .DEPTH(`SMSP_FIFO_DEPTH)) u_fifo (
      .clk       (CLK),
      .rst_n     (RST_N),
      .in_data   (rx_byte),
      .in_valid  (finish),
      .in_ready  (),
      .out_data  (fifo_q),
      .out_valid (fifo_v),
      .out_ready (RX_READY && RX_VALID)
   );
   logic [7:0] rxs_r;
   logic       rxv_r;
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         rxv_r <= 1'b0;
         rxs_r <= 8'h00;
      end else begin
         rxv_r <= fifo_v && !(RX_READY && rxv_r);
         rxs_r <= fifo_q;
      end
   end

   assign CTRL_Q   = ctrl_r;
   assign STATUS_Q = {done_r, write_collision_flag_r, 5'h00, double_r};
   assign RX_DATA  = rxbuf_r;
   assign IRQ      = irq_r;
   assign SCK_O    = sck_r;
   assign SCK_OE   = sck_oe_r;
   assign MOSI_O   = mosi_o_r;
   assign MOSI_OE  = mosi_oe_r;
   assign MISO_O   = miso_o_r;
   assign MISO_OE  = miso_oe_r;
   assign RX_VALID = rxv_r;
   assign RX_STREAM = rxs_r;
endmodule // smsp_port
`default_nettype wire

//--- bench/smsp_port_sva.sv
// Concurrent checks on the serial master/slave port's pins and flags
`timescale 1ns/100ps
`default_nettype none
module smsp_port_chk (
   input  wire logic       CLK,
   input  wire logic       RST_N,
   input  wire logic [7:0] CTRL_Q,
   input  wire logic [7:0] STATUS_Q,
   input  wire logic       IRQ,
   input  wire logic       DATA_WE,
   input  wire logic       DATA_RD,
   input  wire logic       STATUS_RD,
   input  wire logic       IRQ_ACK,
   input  wire logic       SS_IS_INPUT,
   input  wire logic       SS_N_I,
   input  wire logic       MOSI_DIR_OUT,
   input  wire logic       SCK_O,
   input  wire logic       SCK_OE,
   input  wire logic       MOSI_OE,
   input  wire logic       MISO_OE
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);
   wire logic mst       = CTRL_Q[6] && CTRL_Q[4];
   wire logic irq_cause = STATUS_Q[7] && CTRL_Q[7];
   // ----------------------------------------
   // Flag clearing and pin ownership
   // ----------------------------------------
   sequence s_flag_seen;
      STATUS_RD && (STATUS_Q[7] || STATUS_Q[6]);
   endsequence
   sequence s_data_read;
      DATA_RD;
   endsequence
   a_flags_clear_seq: assert property (
      s_flag_seen ##1 s_data_read |=> !STATUS_Q[7] && !STATUS_Q[6])
      else $error("done or collision flag survived status read then data read");
   a_irq_on_done: assert property ($rose(STATUS_Q[7]) && CTRL_Q[7] |=> IRQ)
      else $error("interrupt missing after done with enable");
   a_irq_has_cause: assert property (IRQ |-> $past(irq_cause))
      else $error("interrupt without done and enable");
   a_ack_clears_done: assert property (IRQ_ACK |=> !STATUS_Q[7])
      else $error("vector entry did not clear done");
   a_master_miso_in: assert property (mst ##1 mst |-> !MISO_OE)
      else $error("master drives the slave output line");
   a_slave_pins_in: assert property ((CTRL_Q[6] && !CTRL_Q[4]) [*3] |-> !MOSI_OE && !SCK_OE)
      else $error("slave drives clock or master output line");
   a_mosi_user_dir: assert property ((mst && MOSI_DIR_OUT) [*2] |-> MOSI_OE)
      else $error("master ignores software direction of data out");
   a_idle_miso_off: assert property ((!CTRL_Q[4] && SS_N_I) [*3] |-> !MISO_OE)
      else $error("deselected slave drives its output line");
   a_sck_idle_level: assert property (mst && $rose(STATUS_Q[7]) |-> SCK_O == CTRL_Q[3])
      else $error("clock not at idle level when byte ends");
   a_fast_byte_time: assert property (
      mst && DATA_WE && CTRL_Q[1:0] == 2'b00 && !STATUS_Q[0] |-> ##[30:40] STATUS_Q[7])
      else $error("divide by four byte not done in time");
   a_fault_to_slave: assert property (
      mst && SS_IS_INPUT && !SS_N_I |-> ##[1:4] (!CTRL_Q[4] && STATUS_Q[7]))
      else $error("select low did not drop master mode");
endmodule // smsp_port_chk
bind smsp_port smsp_port_chk smsp_port_chk_i (.*);
`default_nettype wire

//--- bench/smsp_far_slave.sv
// Behavioural serial slave facing the port in master mode
`timescale 1ns/100ps
`default_nettype none
module smsp_far_slave (
   input  wire logic       sck,
   input  wire logic       ss_n,
   input  wire logic       mosi,
   input  wire logic       cpol,
   input  wire logic       cpha,
   input  wire logic       lsb_first,
   input  wire logic [7:0] tx_byte,
   output var  logic       miso,
   output var  logic [7:0] rx_byte
);
   int   k;
   logic bit_q;
   // ----------------------------------------
   // Shift engine
   // ----------------------------------------
   function automatic logic pick(input int i);
      return lsb_first ? tx_byte[i % 8] : tx_byte[7 - i % 8];
   endfunction
   initial begin
      k = 0;
      bit_q = 1'b0;
      rx_byte = 8'h00;
   end
   always @(negedge ss_n) begin
      k = 0;
      bit_q = pick(0);
   end
   always @(sck) begin
      if (!ss_n) begin
         if ((sck != cpol) != cpha) begin
            rx_byte = lsb_first ? {mosi, rx_byte[7:1]} : {rx_byte[6:0], mosi};
            k++;
         end else begin
            bit_q = pick(k);
         end
      end
   end
   // Released line is not pulled: show the inverse so stale data never passes
   assign miso = ss_n ? ~bit_q : bit_q;
endmodule // smsp_far_slave
`default_nettype wire

//--- bench/tb_smsp_port.sv
// Self-checking bench for the serial master/slave port
`timescale 1ns/100ps
`default_nettype none
`define CHK(act, exp) begin num_checks++; if ((act) !== (exp)) begin num_errors++; \
   $display("[FAIL] t=%0t got %h exp %h", $time, act, exp); end end
module tb_smsp_port;
   logic       CLK, RST_N, CTRL_WE, DOUBLE_WDATA, DOUBLE_WE, STATUS_RD, DATA_WE, DATA_RD;
   logic       IRQ_ACK, SS_IS_INPUT, SS_N_I, MOSI_DIR_OUT, SCK_DIR_OUT, MISO_DIR_OUT;
   logic       RX_READY, SCK_O, SCK_OE, MOSI_O, MOSI_OE, MISO_O, MISO_OE, IRQ, RX_VALID;
   logic       far_miso, ext_sck, ext_mosi;
   logic [7:0] CTRL_WDATA, DATA_WDATA, CTRL_Q, STATUS_Q, RX_DATA, reply, far_rx, RX_STREAM;
   logic [7:0] ctab [8] = '{8'hd0, 8'h55, 8'h7a, 8'hdf, 8'h70, 8'hd9, 8'h56, 8'h73};
   int         div_tab [4] = '{4, 16, 64, 128};
   int         num_errors, num_checks;
   wire logic  SCK_I  = SCK_OE ? SCK_O : ext_sck;
   wire logic  MOSI_I = MOSI_OE ? MOSI_O : ext_mosi;
   wire logic  MISO_I = MISO_OE ? MISO_O : far_miso;
   smsp_port smsp_port_i (.*);
   smsp_far_slave smsp_far_slave_i (.sck(SCK_I), .ss_n(SS_N_I), .mosi(MOSI_I), .cpol(CTRL_Q[3]),
      .cpha(CTRL_Q[2]), .lsb_first(CTRL_Q[5]), .tx_byte(reply), .miso(far_miso), .rx_byte(far_rx));
   // ----------------------------------------
   // Bus cycles
   // ----------------------------------------
   task put_ctrl(input logic [7:0] c, input logic d);
      @(posedge CLK) {CTRL_WDATA, CTRL_WE, DOUBLE_WDATA, DOUBLE_WE} <= {c, 1'b1, d, 1'b1};
      @(posedge CLK) {CTRL_WE, DOUBLE_WE} <= 2'b00;
   endtask
   task pulse(input int w);
      @(posedge CLK);
      case (w)
         0: IRQ_ACK <= 1'b1;
         1: DATA_WE <= 1'b1;
         default: RX_READY <= 1'b1;
      endcase
      @(posedge CLK) {IRQ_ACK, DATA_WE, RX_READY} <= 3'b000;
   endtask
   task clear_flags;
      @(posedge CLK) STATUS_RD <= 1'b1;
      @(posedge CLK) {STATUS_RD, DATA_RD} <= 2'b01;
      @(posedge CLK) DATA_RD <= 1'b0;
   endtask
   task wait_done(output int n);
      n = 0;
      while (STATUS_Q[7] !== 1'b1 && n < 2000) begin
         @(negedge CLK);
         n++;
      end
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task master_xfer(input logic [7:0] c, input logic d, input logic [7:0] tx, input logic [7:0] rp);
      int n;
      int dv;
      dv = div_tab[c[1:0]] >> d;
      put_ctrl(c, d);
      reply = rp;
      // Clock moves to its new idle level before the slave is selected
      @(posedge CLK);
      @(posedge CLK) {SS_N_I, DATA_WDATA} <= {1'b0, tx};
      pulse(1);
      wait_done(n);
      `CHK(n >= 8 * dv && n <= 8 * dv + 4, 1'b1)
      `CHK(STATUS_Q[0], d)
      `CHK(far_rx, tx)
      `CHK(RX_DATA, rp)
      @(negedge CLK);
      `CHK(IRQ, c[7])
      clear_flags;
      @(negedge CLK);
      `CHK(STATUS_Q[7], 1'b0)
      @(posedge CLK) SS_N_I <= 1'b1;
   endtask
   task drain;
      for (int i = 0; i < 8; i++) begin
         @(negedge CLK);
         `CHK(RX_VALID, 1'b1)
         `CHK(RX_STREAM, 8'(8'h4b - i * 23))
         pulse(2);
         // Output stage drops valid for one cycle after each pop
         @(posedge CLK);
      end
      @(negedge CLK);
      `CHK(RX_VALID, 1'b0)
   endtask
   task collide;
      int n;
      put_ctrl(8'h51, 1'b0);
      @(posedge CLK) {SS_N_I, DATA_WDATA} <= {1'b0, 8'ha5};
      pulse(1);
      @(posedge CLK) DATA_WDATA <= 8'h5a;
      pulse(1);
      @(negedge CLK);
      `CHK(STATUS_Q[6], 1'b1)
      wait_done(n);
      `CHK(far_rx, 8'ha5)
      clear_flags;
      @(negedge CLK);
      `CHK(STATUS_Q[7:6], 2'b00)
      @(posedge CLK) SS_N_I <= 1'b1;
   endtask
   task mode_fault;
      put_ctrl(8'hd0, 1'b0);
      @(posedge CLK) {SS_IS_INPUT, SS_N_I} <= 2'b10;
      repeat (6) @(negedge CLK);
      `CHK({CTRL_Q[4], STATUS_Q[7]}, 2'b01)
      `CHK(IRQ, 1'b1)
      pulse(0);
      @(negedge CLK);
      `CHK(STATUS_Q[7], 1'b0)
      @(posedge CLK) {SS_IS_INPUT, SS_N_I} <= 2'b01;
   endtask
   task slave_xfer;
      logic [7:0] got;
      put_ctrl(8'h40, 1'b0);
      @(posedge CLK) DATA_WDATA <= 8'hc3;
      pulse(1);
      repeat (8) begin
         repeat (4) @(posedge CLK);
         ext_sck <= ~ext_sck;
      end
      @(negedge CLK);
      `CHK({STATUS_Q[7], MISO_OE}, 2'b00)
      @(posedge CLK) SS_N_I <= 1'b0;
      for (int b = 7; b >= 0; b--) begin
         @(posedge CLK) ext_mosi <= b[0] ^ b[1];
         repeat (4) @(negedge CLK);
         got[b] = MISO_I;
         @(posedge CLK) ext_sck <= 1'b1;
         repeat (4) @(posedge CLK);
         ext_sck <= 1'b0;
      end
      repeat (6) @(negedge CLK);
      `CHK(STATUS_Q[7], 1'b1)
      `CHK(got, 8'hc3)
      `CHK(RX_DATA, 8'h66)
      clear_flags;
      @(posedge CLK) SS_N_I <= 1'b1;
   endtask
   task close_out;
      if (num_errors == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   initial begin
      CLK = 1'b0;
      forever #25 CLK = ~CLK;
   end
   initial begin
      {RST_N, CTRL_WE, DOUBLE_WDATA, DOUBLE_WE, STATUS_RD, DATA_WE, DATA_RD, IRQ_ACK} = 8'h00;
      {SS_IS_INPUT, SS_N_I, MOSI_DIR_OUT, SCK_DIR_OUT, MISO_DIR_OUT} = 5'h0f;
      {RX_READY, ext_sck, ext_mosi, CTRL_WDATA, DATA_WDATA, reply} = 27'h0;
      repeat (20) @(posedge CLK);
      RST_N <= 1'b1;
      @(negedge CLK);
      `CHK({CTRL_Q, STATUS_Q, IRQ}, 17'h0)
      for (int i = 0; i < 8; i++) begin
         master_xfer(ctab[i], i[0] ^ i[2], 8'(8'h96 + i * 37), 8'(8'h4b - i * 23));
      end
      drain;
      collide;
      mode_fault;
      slave_xfer;
      close_out;
   end
   initial begin
      repeat (60000) @(posedge CLK);
      num_errors++;
      close_out;
   end
endmodule // tb_smsp_port
`default_nettype wire
